// ---- core/fcc_defines.vh ----
// Register map, field positions, reset values and command codes of the flash command controller
// Overview of operation
// - Interrupt on enabled complete or collision flag
// - Keep running in wait; completion wakes
// - Stop entry waits for active command
// - Refuse commands in very low power modes
// - Special mode on a secured part limits commands
// - Array reads need only the address
// - Read during running command sets collision
// - Drop parameter writes while command runs
// - Parameter registers writable in any order
// - Write one clears completion, launches command
// - Error flags block launch until cleared
// - Bad code or address sets access error
// - Program/erase into protected region flags violation
// - Failed checks skip execution, set complete
// - Execution failures set runtime status flag
// - Results stored on the edge that sets completion flag
// - Codes 01, 02, 40 verify and check
// - Codes 03, 41 return four bytes
// - Codes 06, 09, 43 program or erase
// - Code 44 needs no protection; 45 keys
// - Normal mode protection only tightens bitwise
// - Colliding read data invalid, flag set
`ifndef FCC_DEFINES_VH
`define FCC_DEFINES_VH
`define FCC_OFS_STATUS 8'h00
`define FCC_OFS_CONFIG 8'h01
`define FCC_OFS_PARAM0 8'h04
`define FCC_OFS_PARAM_LAST 8'h0F
`define FCC_OFS_PROT0 8'h10
`define FCC_OFS_PROT3 8'h13
`define FCC_ST_CMD_COMPLETE 7
`define FCC_ST_READ_COLLISION 6
`define FCC_ST_ACCESS_ERROR 5
`define FCC_ST_PROTECT_VIOL 4
`define FCC_ST_RUNTIME 0
`define FCC_CFG_CC_IRQ_EN 7
`define FCC_CFG_RC_IRQ_EN 6
`define FCC_RST_CONFIG 8'h00
`define FCC_RST_PROT 32'hFFFFFFFF
`define FCC_CMD_READ1_SECTION 8'h01
`define FCC_CMD_PROGRAM_CHECK 8'h02
`define FCC_CMD_READ_RESOURCE 8'h03
`define FCC_CMD_PROGRAM_LONG 8'h06
`define FCC_CMD_ERASE_SECTOR 8'h09
`define FCC_CMD_READ1_ALL 8'h40
`define FCC_CMD_READ_ONCE 8'h41
`define FCC_CMD_PROGRAM_ONCE 8'h43
`define FCC_CMD_ERASE_ALL 8'h44
`define FCC_CMD_BACKDOOR_KEY 8'h45
`define FCC_MARGIN_MAX 8'h02
`define FCC_ONCE_RECORDS 16
`endif

// ---- core/fcc_flash_cmd_ctrl.v ----
// Flash command controller: register port, checks, launch, sequencing and collision detection
`timescale 1ns/10ps
`include "fcc_defines.vh"
module fcc_flash_cmd_ctrl #(
  parameter FLASH_BYTES = 131072
) (
  input wire clock,
  input wire resetn,
  input wire [7:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [7:0] reg_rdata,
  input wire special_mode,
  input wire secure,
  input wire very_low_power,
  input wire stop_req,
  output wire stop_ack,
  input wire [31:0] prot_init,
  input wire [63:0] backdoor_key,
  input wire array_rd,
  output wire read_collision,
  output reg op_start,
  output reg [7:0] op_code,
  output reg [23:0] op_addr,
  output reg [31:0] op_data,
  output reg [15:0] op_count,
  output reg [7:0] op_margin,
  input wire op_done,
  input wire op_fail,
  input wire [31:0] op_rdata,
  output reg security_release,
  output wire irq
);

  localparam ST_IDLE = 2'h0;
  localparam ST_CHECK = 2'h1;
  localparam ST_RUN = 2'h2;
  localparam NPARAM = 12;
  localparam [31:0] FLASH_BYTES_W = FLASH_BYTES;
  localparam [31:0] REGION_BYTES_W = FLASH_BYTES_W / 32;
  localparam [23:0] FLASH_SIZE = FLASH_BYTES_W[23:0];
  localparam [23:0] REGION_BYTES = REGION_BYTES_W[23:0];

  reg [1:0] state_reg;
  reg cmd_complete_flag;
  reg read_collision_flag;
  reg access_error_flag;
  reg protect_violation_flag;
  reg runtime_status_flag;
  reg cmd_complete_irq_en;
  reg read_collision_irq_en;
  reg [31:0] region_protect_bits;
  reg prot_loaded_reg;
  reg [15:0] once_used_reg;
  reg [7:0] cmd_param_regs [0:NPARAM-1];

  wire st_wr = reg_wr && (reg_addr == `FCC_OFS_STATUS);
  wire cfg_wr = reg_wr && (reg_addr == `FCC_OFS_CONFIG);
  wire prm_hit = (reg_addr >= `FCC_OFS_PARAM0) && (reg_addr <= `FCC_OFS_PARAM_LAST);
  wire [7:0] prm_rel = reg_addr - `FCC_OFS_PARAM0;
  wire [7:0] prot_rel = reg_addr - `FCC_OFS_PROT0;
  wire prot_hit = (reg_addr >= `FCC_OFS_PROT0) && (reg_addr <= `FCC_OFS_PROT3);
  wire errors_set = access_error_flag || protect_violation_flag;
  // Launch: write one to completion flag, idle, no pending errors, not in low power
  wire launch = st_wr && reg_wdata[`FCC_ST_CMD_COMPLETE] && cmd_complete_flag && !errors_set
    && !very_low_power;

  // Decoded parameters of the command being checked
  wire [7:0] cmd_code_field = cmd_param_regs[0];
  wire [23:0] cmd_addr = {cmd_param_regs[1], cmd_param_regs[2], cmd_param_regs[3]};
  wire [15:0] cmd_count = {cmd_param_regs[4], cmd_param_regs[5]};
  wire [31:0] cmd_word = {cmd_param_regs[4], cmd_param_regs[5], cmd_param_regs[6], cmd_param_regs[7]};
  wire [63:0] cmd_key = {cmd_word, cmd_param_regs[8], cmd_param_regs[9], cmd_param_regs[10], cmd_param_regs[11]};
  wire [23:0] region_w = cmd_addr / REGION_BYTES;
  wire [23:0] end_addr = cmd_addr + {6'h00, cmd_count, 2'h0};
  wire [3:0] once_idx = cmd_param_regs[1][3:0];

  reg known_code;
  reg mode_ok;
  reg param_bad;
  reg protect_bad;
  reg local_cmd;
  always @* begin
    known_code = 1'b1;
    param_bad = 1'b0;
    protect_bad = 1'b0;
    local_cmd = 1'b0;
    // Special mode on a secured part allows only the whole-block commands
    mode_ok = !(special_mode && secure) || (cmd_code_field == `FCC_CMD_READ1_ALL)
      || (cmd_code_field == `FCC_CMD_ERASE_ALL);
    case (cmd_code_field)
      `FCC_CMD_READ1_SECTION: begin
        param_bad = (cmd_addr >= FLASH_SIZE) || (cmd_addr[1:0] != 2'h0) || (cmd_count == 16'h0000)
          || (end_addr > FLASH_SIZE) || (cmd_param_regs[6] > `FCC_MARGIN_MAX);
      end
      `FCC_CMD_PROGRAM_CHECK: begin
        param_bad = (cmd_addr >= FLASH_SIZE) || (cmd_addr[1:0] != 2'h0);
      end
      `FCC_CMD_READ_RESOURCE: begin
        param_bad = (cmd_addr[1:0] != 2'h0);
      end
      `FCC_CMD_PROGRAM_LONG, `FCC_CMD_ERASE_SECTOR: begin
        param_bad = (cmd_addr >= FLASH_SIZE) || (cmd_addr[1:0] != 2'h0);
        protect_bad = !param_bad && !region_protect_bits[region_w[4:0]];
      end
      `FCC_CMD_READ1_ALL: begin
        param_bad = 1'b0;
      end
      `FCC_CMD_READ_ONCE: begin
        param_bad = (cmd_param_regs[1] >= `FCC_ONCE_RECORDS);
      end
      `FCC_CMD_PROGRAM_ONCE: begin
        param_bad = (cmd_param_regs[1] >= `FCC_ONCE_RECORDS) || once_used_reg[once_idx];
      end
      `FCC_CMD_ERASE_ALL: begin
        protect_bad = (region_protect_bits != `FCC_RST_PROT);
      end
      `FCC_CMD_BACKDOOR_KEY: begin
        local_cmd = 1'b1;
        param_bad = (cmd_key != backdoor_key);
      end
      default: begin
        known_code = 1'b0;
      end
    endcase
  end
  wire acc_fail = !known_code || !mode_ok || param_bad;

  // Command sequencer
  always @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      state_reg <= ST_IDLE;
      op_start <= 1'b0;
      op_code <= 8'h00;
      op_addr <= 24'h000000;
      op_data <= 32'h00000000;
      op_count <= 16'h0000;
      op_margin <= 8'h00;
      security_release <= 1'b0;
    end else begin
      op_start <= 1'b0;
      security_release <= 1'b0;
      case (state_reg)
        ST_IDLE: begin
          if (launch) begin
            state_reg <= ST_CHECK;
          end
        end
        ST_CHECK: begin
          if (acc_fail || protect_bad) begin
            state_reg <= ST_IDLE;
          end else if (local_cmd) begin
            security_release <= 1'b1;
            state_reg <= ST_IDLE;
          end else begin
            op_start <= 1'b1;
            op_code <= cmd_code_field;
            op_addr <= cmd_addr;
            op_data <= cmd_word;
            op_count <= cmd_count;
            op_margin <= cmd_param_regs[6];
            state_reg <= ST_RUN;
          end
        end
        ST_RUN: begin
          if (op_done) begin
            security_release <= !op_fail && ((op_code == `FCC_CMD_READ1_ALL) || (op_code == `FCC_CMD_ERASE_ALL));
            state_reg <= ST_IDLE;
          end
        end
        default: begin
          state_reg <= ST_IDLE;
        end
      endcase
    end
  end

  wire check_end = (state_reg == ST_CHECK) && (acc_fail || protect_bad || local_cmd);
  wire run_end = (state_reg == ST_RUN) && op_done;
  wire returns_data = (op_code == `FCC_CMD_READ_RESOURCE) || (op_code == `FCC_CMD_READ_ONCE);

  // Status flags; hardware set wins over a software clear in the same cycle
  always @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      cmd_complete_flag <= 1'b1;
      read_collision_flag <= 1'b0;
      access_error_flag <= 1'b0;
      protect_violation_flag <= 1'b0;
      runtime_status_flag <= 1'b0;
      once_used_reg <= 16'h0000;
    end else begin
      if (launch) begin
        cmd_complete_flag <= 1'b0;
        runtime_status_flag <= 1'b0;
      end else if (check_end || run_end) begin
        cmd_complete_flag <= 1'b1;
      end
      if (check_end && acc_fail) begin
        access_error_flag <= 1'b1;
      end else if (st_wr && reg_wdata[`FCC_ST_ACCESS_ERROR]) begin
        access_error_flag <= 1'b0;
      end
      if (check_end && !acc_fail && protect_bad) begin
        protect_violation_flag <= 1'b1;
      end else if (st_wr && reg_wdata[`FCC_ST_PROTECT_VIOL]) begin
        protect_violation_flag <= 1'b0;
      end
      if (read_collision) begin
        read_collision_flag <= 1'b1;
      end else if (st_wr && reg_wdata[`FCC_ST_READ_COLLISION]) begin
        read_collision_flag <= 1'b0;
      end
      if (run_end && op_fail) begin
        runtime_status_flag <= 1'b1;
      end
      if (run_end && !op_fail && (op_code == `FCC_CMD_PROGRAM_ONCE)) begin
        once_used_reg[op_addr[19:16]] <= 1'b1;
      end
    end
  end

  // Parameter registers: any order while idle, results loaded on the same edge that sets completion
  genvar gi;
  generate
    for (gi = 0; gi < NPARAM; gi = gi + 1) begin : g_param
      always @(posedge clock or negedge resetn) begin
        if (!resetn) begin
          cmd_param_regs[gi] <= 8'h00;
        end else if (run_end && returns_data && (gi >= 4) && (gi <= 7)) begin
          cmd_param_regs[gi] <= op_rdata[((7 - gi) & 3) * 8 + 7 -: 8];
        end else if (reg_wr && prm_hit && (prm_rel == gi) && cmd_complete_flag) begin
          cmd_param_regs[gi] <= reg_wdata;
        end
      end
    end
  endgenerate

  // Configuration and protection registers
  always @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      cmd_complete_irq_en <= 1'b0;
      read_collision_irq_en <= 1'b0;
      region_protect_bits <= `FCC_RST_PROT;
      prot_loaded_reg <= 1'b0;
    end else begin
      if (cfg_wr) begin
        cmd_complete_irq_en <= reg_wdata[`FCC_CFG_CC_IRQ_EN];
        read_collision_irq_en <= reg_wdata[`FCC_CFG_RC_IRQ_EN];
      end
      if (!prot_loaded_reg) begin
        prot_loaded_reg <= 1'b1;
        region_protect_bits <= prot_init;
      end else if (reg_wr && prot_hit && cmd_complete_flag) begin
        case (prot_rel[1:0])
          2'h0: region_protect_bits[31:24] <= special_mode ? reg_wdata : (region_protect_bits[31:24] & reg_wdata);
          2'h1: region_protect_bits[23:16] <= special_mode ? reg_wdata : (region_protect_bits[23:16] & reg_wdata);
          2'h2: region_protect_bits[15:8] <= special_mode ? reg_wdata : (region_protect_bits[15:8] & reg_wdata);
          default: region_protect_bits[7:0] <= special_mode ? reg_wdata : (region_protect_bits[7:0] & reg_wdata);
        endcase
      end
    end
  end

  // Read data stand for the cycle after the strobe only
  reg [7:0] rd_mux;
  always @* begin
    rd_mux = 8'h00;
    if (reg_addr == `FCC_OFS_STATUS) begin
      rd_mux = {cmd_complete_flag, read_collision_flag, access_error_flag, protect_violation_flag,
        3'h0, runtime_status_flag};
    end else if (reg_addr == `FCC_OFS_CONFIG) begin
      rd_mux = {cmd_complete_irq_en, read_collision_irq_en, 6'h00};
    end else if (prm_hit) begin
      rd_mux = cmd_param_regs[prm_rel[3:0]];
    end else if (prot_hit) begin
      case (prot_rel[1:0])
        2'h0: rd_mux = region_protect_bits[31:24];
        2'h1: rd_mux = region_protect_bits[23:16];
        2'h2: rd_mux = region_protect_bits[15:8];
        default: rd_mux = region_protect_bits[7:0];
      endcase
    end
  end

  always @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      reg_rdata <= 8'h00;
    end else begin
      reg_rdata <= reg_rd ? rd_mux : 8'h00;
    end
  end

  // Plain array reads are served by the array from the address alone; only conflicts are flagged
  assign read_collision = array_rd && !cmd_complete_flag;
  // Stop entry is held off until the running command completes
  assign stop_ack = stop_req && cmd_complete_flag;
  // Interrupt does not depend on wait state, so completion can wake the core
  assign irq = (cmd_complete_flag && cmd_complete_irq_en)
    || (read_collision_flag && read_collision_irq_en);

endmodule

// ---- sim/fcc_flash_cmd_ctrl_assertions.sv ----
// Port-level checker of the flash command controller
`timescale 1ns/10ps
module fcc_flash_cmd_ctrl_assertions #(
  parameter FLASH_BYTES = 131072
) (
  input wire clock,
  input wire resetn,
  input wire [7:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_wr,
  input wire very_low_power,
  input wire stop_req,
  input wire stop_ack,
  input wire array_rd,
  input wire read_collision,
  input wire op_start,
  input wire op_done
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!resetn);
  sequence done_s;
    op_done ##1 stop_req;
  endsequence
  sequence launch_s;
    op_start ##1 !op_start [*3];
  endsequence
  stop_needs_req_a: assert property (stop_ack |-> stop_req) else $error("stop ack without request");
  stop_hold_run_a: assert property (op_start |-> !stop_ack) else $error("stop ack during command");
  stop_after_done_a: assert property (done_s |-> stop_ack) else $error("no stop ack after done");
  coll_when_run_a: assert property (op_start && array_rd |-> read_collision) else $error("collision missed");
  coll_needs_rd_a: assert property (read_collision |-> array_rd) else $error("collision without read");
  launch_walk_a: assert property (op_start |-> $past(reg_wr && reg_addr == 8'h00 && reg_wdata[7], 2))
    else $error("start without launch write");
  vlp_refuse_a: assert property (op_start |-> !$past(very_low_power, 2)) else $error("start in low power");
  start_single_a: assert property (op_start |-> launch_s) else $error("start repeated");
  cover property (done_s);
endmodule
bind fcc_flash_cmd_ctrl fcc_flash_cmd_ctrl_assertions #(.FLASH_BYTES(FLASH_BYTES)) fcc_flash_cmd_ctrl_assertions_inst (
  .clock, .resetn, .reg_addr, .reg_wdata, .reg_wr, .very_low_power, .stop_req, .stop_ack, .array_rd,
  .read_collision, .op_start, .op_done);

// ---- sim/fcc_flash_cmd_ctrl_tb_top.sv ----
// Self-checking bench of the flash command controller
`timescale 1ns/10ps
module fcc_flash_cmd_ctrl_tb_top;
  reg clock = 1'b0;
  reg resetn = 1'b0;
  reg [7:0] reg_addr = 8'h00;
  reg [7:0] reg_wdata = 8'h00;
  reg reg_wr = 1'b0;
  reg reg_rd = 1'b0;
  reg special_mode = 1'b0;
  reg secure = 1'b0;
  reg very_low_power = 1'b0;
  reg stop_req = 1'b0;
  reg array_rd = 1'b0;
  reg fail_mode = 1'b0;
  wire [7:0] reg_rdata;
  wire [7:0] op_code;
  wire [31:0] op_rdata;
  wire [23:0] op_addr;
  wire [31:0] op_data;
  wire [15:0] op_count;
  wire [7:0] op_margin;
  localparam [63:0] KEY_VALUE = 64'h0123456789ABCDEF;
  wire stop_ack, read_collision, op_start, op_done, op_fail, security_release, irq;
  integer miscompares = 0;
  integer compares = 0;
  integer releases = 0;
  reg [7:0] s;
  always #50 clock = ~clock;
  always @(posedge clock) begin
    if (security_release === 1'b1) begin
      releases <= releases + 1;
    end
  end
  fcc_flash_model fcc_flash_model_inst (.clock(clock), .resetn(resetn), .op_start(op_start),
    .fail_mode(fail_mode), .op_done(op_done), .op_fail(op_fail), .op_rdata(op_rdata));
  fcc_flash_cmd_ctrl fcc_flash_cmd_ctrl_inst (.clock(clock), .resetn(resetn), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .special_mode(special_mode), .secure(secure), .very_low_power(very_low_power), .stop_req(stop_req),
    .stop_ack(stop_ack), .prot_init(32'hFFFFFF0F), .backdoor_key(KEY_VALUE), .array_rd(array_rd),
    .read_collision(read_collision), .op_start(op_start), .op_code(op_code), .op_addr(op_addr),
    .op_data(op_data), .op_count(op_count), .op_margin(op_margin), .op_done(op_done), .op_fail(op_fail),
    .op_rdata(op_rdata),
    .security_release(security_release), .irq(irq));
  task chk8(input [7:0] got, input [7:0] exp);
    chk32({24'h000000, got}, {24'h000000, exp});
  endtask
  task chk32(input [31:0] got, input [31:0] exp);
    begin
      compares = compares + 1;
      if (got !== exp) begin
        miscompares = miscompares + 1;
        $display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
      end
    end
  endtask
  task chk1(input got, input exp);
    chk8({7'h0, got}, {7'h0, exp});
  endtask
  task wr(input [7:0] a, input [7:0] d);
    begin
      @(posedge clock);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clock);
      reg_wr <= 1'b0;
      #10;
    end
  endtask
  task rd(input [7:0] a, output [7:0] d);
    begin
      @(posedge clock);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clock);
      reg_rd <= 1'b0;
      #10 d = reg_rdata;
    end
  endtask
  task rchk(input [7:0] a, input [7:0] exp);
    begin
      rd(a, s);
      chk8(s, exp);
    end
  endtask
  task launch(input [7:0] c, input [23:0] a);
    begin
      wr(8'h07, a[7:0]);
      wr(8'h06, a[15:8]);
      wr(8'h05, a[23:16]);
      wr(8'h04, c);
      wr(8'h00, 8'h80);
    end
  endtask
  task finish;
    integer n;
    begin
      n = 0;
      s = 8'h00;
      while (s[7] !== 1'b1 && n < 40) begin
        rd(8'h00, s);
        n = n + 1;
      end
    end
  endtask
  task t_reset;
    begin
      rchk(8'h00, 8'h80);
      rchk(8'h01, 8'h00);
      rchk(8'h13, 8'h0F);
      rchk(8'h20, 8'h00);
      $display("reset test done");
    end
  endtask
  task t_program;
    begin
      wr(8'h01, 8'h80);
      chk1(irq, 1'b1);
      launch(8'h06, 24'h000100);
      chk1(irq, 1'b0);
      wr(8'h04, 8'h09);
      finish;
      chk8(s, 8'h80);
      chk1(irq, 1'b1);
      chk8(op_code, 8'h06);
      rchk(8'h04, 8'h06);
      launch(8'h03, 24'h000000);
      finish;
      rchk(8'h08, 8'hA5);
      rchk(8'h09, 8'hC3);
      rchk(8'h0A, 8'h0F);
      rchk(8'h0B, 8'h1E);
      $display("program test done");
    end
  endtask
  task t_errors;
    begin
      launch(8'hFF, 24'h000000);
      finish;
      chk8(s, 8'hA0);
      wr(8'h00, 8'h00);
      rchk(8'h00, 8'hA0);
      wr(8'h00, 8'h80);
      rchk(8'h00, 8'hA0);
      wr(8'h00, 8'h20);
      rchk(8'h00, 8'h80);
      @(posedge clock);
      special_mode <= 1'b1;
      secure <= 1'b1;
      launch(8'h06, 24'h000100);
      finish;
      chk8(s, 8'hA0);
      wr(8'h00, 8'h20);
      @(posedge clock);
      special_mode <= 1'b0;
      secure <= 1'b0;
      launch(8'h06, 24'h004000);
      finish;
      chk8(s, 8'h90);
      wr(8'h00, 8'h10);
      wr(8'h13, 8'hFF);
      rchk(8'h13, 8'h0F);
      wr(8'h13, 8'h0E);
      rchk(8'h13, 8'h0E);
      @(posedge clock);
      fail_mode <= 1'b1;
      launch(8'h09, 24'h001000);
      finish;
      chk8(s, 8'h81);
      @(posedge clock);
      fail_mode <= 1'b0;
      $display("error test done");
    end
  endtask
  task t_collide;
    begin
      wr(8'h01, 8'h40);
      @(posedge clock);
      stop_req <= 1'b1;
      launch(8'h06, 24'h001200);
      chk1(stop_ack, 1'b0);
      @(posedge clock);
      array_rd <= 1'b1;
      #10 chk1(read_collision, 1'b1);
      @(posedge clock);
      array_rd <= 1'b0;
      finish;
      chk8(s, 8'hC0);
      chk1(stop_ack, 1'b1);
      chk1(irq, 1'b1);
      wr(8'h00, 8'h40);
      rchk(8'h00, 8'h80);
      chk1(irq, 1'b0);
      @(posedge clock);
      stop_req <= 1'b0;
      very_low_power <= 1'b1;
      launch(8'h06, 24'h001300);
      rchk(8'h00, 8'h80);
      @(posedge clock);
      very_low_power <= 1'b0;
      $display("collision and power test done");
    end
  endtask
  task t_codes;
    integer i;
    begin
      launch(8'h01, 24'h000000);
      finish;
      chk8(s, 8'hA0);
      wr(8'h00, 8'h20);
      wr(8'h08, 8'h00);
      wr(8'h09, 8'h02);
      wr(8'h0A, 8'h01);
      launch(8'h01, 24'h000400);
      finish;
      chk8(s, 8'h80);
      chk32({8'h00, op_addr}, 32'h00000400);
      chk32({16'h0000, op_count}, 32'h00000002);
      chk32({24'h000000, op_margin}, 32'h00000001);
      chk32(op_data, 32'h0002011E);
      launch(8'h41, 24'h100000);
      finish;
      chk8(s, 8'hA0);
      wr(8'h00, 8'h20);
      launch(8'h43, 24'h020000);
      finish;
      chk8(s, 8'h80);
      launch(8'h43, 24'h020000);
      finish;
      chk8(s, 8'hA0);
      wr(8'h00, 8'h20);
      launch(8'h44, 24'h000000);
      finish;
      chk8(s, 8'h90);
      wr(8'h00, 8'h10);
      launch(8'h45, 24'h000000);
      finish;
      chk8(s, 8'hA0);
      chk32(releases, 32'h00000000);
      wr(8'h00, 8'h20);
      for (i = 0; i < 8; i = i + 1) begin
        wr(8'h08 + i[7:0], KEY_VALUE[63 - 8 * i -: 8]);
      end
      launch(8'h45, 24'h000000);
      finish;
      chk8(s, 8'h80);
      chk32(releases, 32'h00000001);
      @(posedge clock);
      special_mode <= 1'b1;
      secure <= 1'b1;
      launch(8'h40, 24'h000000);
      finish;
      chk8(s, 8'h80);
      chk32(releases, 32'h00000002);
      launch(8'h02, 24'h000000);
      finish;
      chk8(s, 8'hA0);
      wr(8'h00, 8'h20);
      @(posedge clock);
      special_mode <= 1'b0;
      secure <= 1'b0;
      $display("command code test done");
    end
  endtask
  task conclude;
    begin
      $display("compares=%0d miscompares=%0d", compares, miscompares);
      if (miscompares == 0 && compares > 0)
        $display("ALL TESTS PASSED");
      else
        $display("TESTS FAILED");
      $finish;
    end
  endtask
  initial begin
    #1000000;
    miscompares = miscompares + 1;
    conclude;
  end
  initial begin
    repeat (6) @(posedge clock);
    resetn <= 1'b1;
    repeat (2) @(posedge clock);
    t_reset;
    t_program;
    t_errors;
    t_collide;
    t_codes;
    conclude;
  end
endmodule

// ---- sim/fcc_flash_model.sv ----
// Behavioural flash macro answering operation requests
`timescale 1ns/10ps
module fcc_flash_model (
  input wire clock,
  input wire resetn,
  input wire op_start,
  input wire fail_mode,
  output reg op_done,
  output reg op_fail,
  output reg [31:0] op_rdata
);
  reg [3:0] cnt_reg;
  always @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      cnt_reg <= 4'h0;
      op_done <= 1'b0;
      op_fail <= 1'b0;
      op_rdata <= 32'h0;
    end else begin
      cnt_reg <= op_start ? 4'h5 : (cnt_reg != 4'h0) ? cnt_reg - 4'h1 : 4'h0;
      op_done <= (cnt_reg == 4'h1);
      op_fail <= (cnt_reg == 4'h1) & fail_mode;
      op_rdata <= (cnt_reg == 4'h1) ? 32'hA5C30F1E : ~op_rdata;
    end
  end
endmodule
